// ### pcrs_core.sv
// Program counter and hardware return stack with Wishbone register access.
// Assumes the core sequencer issues one operation per cycle on op_i.
`timescale 1ns/100ps
module pcrs_core
  import pcrs_pkg::*;
(
  // Clock and reset.
  input  wire logic            core_clk_i,
  input  wire logic            rst_n_i,
  input  wire logic            por_n_i,
  // Core sequencer.
  input  wire logic [3:0]      op_i,
  input  wire logic [PC_W-1:0] target_i,
  output logic      [PC_W-1:0] pc_o,
  output logic                 stack_reset_o,
  // Program fetch.
  input  wire logic [15:0]     fetch_data_i,
  output logic      [15:0]     fetch_word_o,
  // Wishbone slave.
  input  wire logic            cyc_i,
  input  wire logic            stb_i,
  input  wire logic            we_i,
  input  wire logic [4:0]      adr_i,
  input  wire logic [3:0]      sel_i,
  input  wire logic [31:0]     dat_i,
  output logic      [31:0]     dat_o,
  output logic                 ack_o
);

  logic [PC_W-1:0] pc_reg;
  logic [7:0]      lath_reg;
  logic [4:0]      latu_reg;
  logic [SP_W-1:0] sp_reg;
  logic            full_reg;
  logic            unf_reg;
  logic            opt_reg;
  logic            srst_reg;
  logic [PC_W-1:0] stk_mem [1:DEPTH];  // [R8] No entry behind pointer zero. [R12]

  // Bus decode.
  wire bus_req = cyc_i & stb_i & ~ack_o;
  wire wr_en   = bus_req & we_i & sel_i[0];
  wire rd_en   = bus_req & ~we_i;
  wire wr_cnt_low = wr_en & (adr_i == OFS_CNT_LOW);
  wire rd_cnt_low = rd_en & (adr_i == OFS_CNT_LOW);
  wire wr_stk     = wr_en & (adr_i == OFS_STK);
  wire wr_top_low = wr_en & (adr_i == OFS_TOP_LOW);
  wire wr_top_mid = wr_en & (adr_i == OFS_TOP_MID);
  wire wr_top_up  = wr_en & (adr_i == OFS_TOP_UP);
  wire has_top = (sp_reg != SP_ZERO);
  wire [PC_W-1:0] top_entry = has_top ? stk_mem[sp_reg] : RESET_VEC;  // [R13]

  // Operation decode.
  pcrs_op_t op;
  assign op = pcrs_op_t'(op_i);
  wire is_push = (op == OP_CALL) | (op == OP_INT_HI) | (op == OP_INT_LO)
               | (op == OP_PUSH);  // [R9] [R21]
  wire is_ret  = (op == OP_RET);   // [R9]
  wire is_pop  = (op == OP_POP);   // [R21]
  wire at_max  = (sp_reg == SP_MAX);
  wire sp_inc_last = (sp_reg == SP_MAX - 5'h01);
  wire push_ok = is_push & ~at_max;                      // [R17]
  wire full_ev = is_push & (sp_inc_last | at_max);       // [R15]
  wire unf_ev  = (is_ret | is_pop) & ~has_top;           // [R18]
  wire trip    = opt_reg & (full_ev | unf_ev);           // [R19]
  wire [SP_W-1:0] sp_up = sp_reg + 5'h01;                // [R10]
  wire [PC_W-1:0] pc_seq = pc_reg + PC_STEP;             // [R6]
  wire [PC_W-1:0] push_val = (opt_reg & sp_inc_last) ? pc_seq : pc_reg;  // [R16]
  wire [PC_W-1:0] cnt_low_val = {latu_reg, lath_reg, dat_i[7:1], 1'b0};  // [R4] [R6]

  // Next counter value by operation.
  logic [PC_W-1:0] pc_next;
  always_comb
  begin
    pc_next = pc_reg;
    unique case (op)
      OP_STEP:   pc_next = pc_seq;                              // [R6]
      OP_JUMP,
      OP_CALL:   pc_next = {target_i[PC_W-1:1], 1'b0};          // [R7]
      OP_RET:    pc_next = has_top ? top_entry : RESET_VEC;     // [R11] [R18]
      OP_INT_HI: pc_next = VEC_HIGH;                            // [R2]
      OP_INT_LO: pc_next = VEC_LOW;                             // [R2]
      default:   pc_next = pc_reg;
    endcase
    if (trip)
      pc_next = RESET_VEC;                                      // [R19]
    else if (wr_cnt_low)
      pc_next = cnt_low_val;                                    // [R4]
  end

  // Next pointer value.
  logic [SP_W-1:0] sp_next;
  always_comb
  begin
    sp_next = sp_reg;
    if (trip)
      sp_next = SP_ZERO;                                        // [R16] [R19]
    else if (push_ok)
      sp_next = sp_up;                                          // [R10] [R17]
    else if ((is_ret | is_pop) & has_top)
      sp_next = sp_reg - 5'h01;                                 // [R11] [R21]
    else if (wr_stk)
      sp_next = dat_i[SP_W-1:0];                                // [R14]
  end

  // Counter and latch registers; a device reset clears the counter and both latches.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      pc_reg   <= RESET_VEC;                                    // [R2]
      lath_reg <= 8'h00;
      latu_reg <= 5'h00;
    end
    else
    begin
      pc_reg <= pc_next;
      if (rd_cnt_low)
      begin
        lath_reg <= pc_reg[15:8];                               // [R5]
        latu_reg <= pc_reg[20:16];                              // [R5]
      end
      else if (wr_en & (adr_i == OFS_LATH))
        lath_reg <= dat_i[7:0];
      else if (wr_en & (adr_i == OFS_LATU))
        latu_reg <= dat_i[4:0];
    end
  end

  // Pointer; a device reset or a trip clears it, a power-on reset alone does not.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      sp_reg <= SP_ZERO;                                        // [R12]
    else
      sp_reg <= sp_next;
  end

  // Flags survive device resets; hardware set wins over software clear.
  always_ff @(posedge core_clk_i)
  begin
    if (!por_n_i)
    begin
      full_reg <= 1'b0;                                         // [R20]
      unf_reg  <= 1'b0;
    end
    else
    begin
      full_reg <= full_ev | (full_reg & ~(wr_stk & ~dat_i[BIT_FULL]));  // [R15] [R20]
      unf_reg  <= unf_ev | (unf_reg & ~(wr_stk & ~dat_i[BIT_UNF]));     // [R18] [R20]
    end
  end

  // Overflow reset option, written through the configuration register.
  always_ff @(posedge core_clk_i)
  begin
    if (!por_n_i)
      opt_reg <= CFG_RESET;
    else if (wr_en & (adr_i == OFS_CFG))
      opt_reg <= dat_i[0];
  end

  // Stack storage: hardware push or top entry byte writes.
  always_ff @(posedge core_clk_i)
  begin
    if (push_ok & rst_n_i)
      stk_mem[sp_up] <= push_val;                               // [R10] [R16]
    else if (has_top & rst_n_i)
    begin
      if (wr_top_low)
        stk_mem[sp_reg] <= {top_entry[20:8], dat_i[7:0]};       // [R13]
      else if (wr_top_mid)
        stk_mem[sp_reg] <= {top_entry[20:16], dat_i[7:0], top_entry[7:0]};
      else if (wr_top_up)
        stk_mem[sp_reg] <= {dat_i[4:0], top_entry[15:0]};
    end
  end

  // Read mux.
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h00000000;
    unique case (adr_i)
      OFS_CNT_LOW: rd_data = {24'h000000, pc_reg[7:0]};         // [R3]
      OFS_LATH: rd_data = {24'h000000, lath_reg};
      OFS_LATU: rd_data = {27'h0000000, latu_reg};
      OFS_STK:  rd_data = {24'h000000, full_reg, unf_reg, 1'b0, sp_reg};  // [R20]
      OFS_TOP_LOW: rd_data = {24'h000000, top_entry[7:0]};
      OFS_TOP_MID: rd_data = {24'h000000, top_entry[15:8]};
      OFS_TOP_UP:  rd_data = {27'h0000000, top_entry[20:16]};
      OFS_CFG:  rd_data = {31'h00000000, opt_reg};
      default:  rd_data = 32'h00000000;
    endcase
  end

  // Bus answer, fetch filter and reset pulse outputs.
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_o        <= 1'b0;
      dat_o        <= 32'h00000000;
      fetch_word_o <= 16'h0000;
      srst_reg     <= 1'b0;
    end
    else
    begin
      ack_o        <= bus_req;
      dat_o        <= rd_en ? rd_data : 32'h00000000;
      fetch_word_o <= (pc_reg > MEM_TOP) ? 16'h0000 : fetch_data_i;  // [R1]
      srst_reg     <= trip;                                          // [R19]
    end
  end

  assign pc_o          = pc_reg;
  assign stack_reset_o = srst_reg;

endmodule

// ### pcrs_core_checker.sv
// Port assertions for the program counter and return stack block.
// Assumes one core clock and a synchronous active-low reset.
`timescale 1ns/100ps
module pcrs_core_checker
  import pcrs_pkg::*;
(
  // Clock, reset and watched ports.
  input wire logic            core_clk_i,
  input wire logic            rst_n_i,
  input wire logic [3:0]      op_i,
  input wire logic [PC_W-1:0] target_i,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic            stack_reset_o,
  input wire logic [15:0]     fetch_word_o,
  input wire logic            cyc_i,
  input wire logic            stb_i,
  input wire logic            ack_o
);
  // All checks sample on the core clock; all but reset_vec_a rest while reset is low.
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  ack_take_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  ack_single_a: assert property (ack_o |=> !ack_o) else $error("long ack");
  pc_even_a: assert property (pc_o[0] == 1'b0) else $error("odd pc");
  step_add_a: assert property (op_i == OP_STEP |=> pc_o == $past(pc_o) + PC_STEP)
    else $error("bad step");
  jump_load_a: assert property (op_i == OP_JUMP |=> pc_o == {$past(target_i[PC_W-1:1]), 1'b0})
    else $error("bad jump");
  vector_high_a: assert property (op_i == OP_INT_HI |=> pc_o == VEC_HIGH || pc_o == RESET_VEC)
    else $error("bad vector");
  fetch_zero_a: assert property (pc_o > MEM_TOP && $past(pc_o) > MEM_TOP |-> fetch_word_o == 16'h0)
    else $error("fetch not zero");
  trip_pulse_a: assert property (stack_reset_o |=> !stack_reset_o) else $error("long trip");
  reset_vec_a: assert property (disable iff (1'b0) !rst_n_i |=> pc_o == RESET_VEC && !ack_o)
    else $error("bad reset");
endmodule
bind pcrs_core pcrs_core_checker pcrs_core_checker_inst (.core_clk_i, .rst_n_i, .op_i,
  .target_i, .pc_o, .stack_reset_o, .fetch_word_o, .cyc_i, .stb_i, .ack_o);

// ### pcrs_pkg.sv
// Constants and register map for the program counter and return stack block.
// Assumes a classic Wishbone slave with 32-bit data, byte address on adr_i.
// Overview of operation
// [R1] 21-bit counter; fetch beyond memory returns zero
// [R2] Reset starts at 0000h; interrupts vector 0008h/0018h
// [R3] Counter split into low, middle, upper bytes
// [R4] Low byte write loads latches into counter
// [R5] Low byte read copies counter into latches
// [R6] Bit zero fixed low; advance by two; returns load entry bit zero, which a top entry low byte write can set
// [R7] Calls, gotos, branches load counter directly
// [R8] Stack is 31 by 21 bits, 5-bit pointer
// [R9] Calls/interrupts push; returns pop; latches untouched
// [R10] Push increments pointer then writes entry
// [R11] Pop reads entry then decrements pointer
// [R12] Reset clears pointer; zero is empty state
// [R13] Top entry registers access selected entry
// [R14] Software reads and writes pointer, 0 to 31
// [R15] Full flag set after 31 pushes
// [R16] Option set: 31st push stores PC+2, resets
// [R17] Option clear: pointer stops at 31, no overwrite
// [R18] Underflow pop loads zero, flags, pointer stays
// [R19] Option set: full or underflow resets device
// [R20] Flags bits 7,6; bit 5 zero; pointer 4:0
// [R21] Software push stores counter; pop only decrements
// [R22] Software disables interrupts around stack access
package pcrs_pkg;
  localparam int PC_W    = 21;
  localparam int SP_W    = 5;
  localparam int DEPTH   = 31;
  localparam logic [SP_W-1:0] SP_MAX  = 5'h1F;
  localparam logic [SP_W-1:0] SP_ZERO = 5'h00;
  localparam logic [PC_W-1:0] RESET_VEC = 21'h000000;
  localparam logic [PC_W-1:0] VEC_HIGH  = 21'h000008;
  localparam logic [PC_W-1:0] VEC_LOW   = 21'h000018;
  localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
  localparam logic [PC_W-1:0] MEM_TOP   = 21'h001FFF;
  // Byte offsets of the register map.
  localparam logic [4:0] OFS_CNT_LOW = 5'h00;
  localparam logic [4:0] OFS_LATH  = 5'h04;
  localparam logic [4:0] OFS_LATU  = 5'h08;
  localparam logic [4:0] OFS_STK   = 5'h0C;
  localparam logic [4:0] OFS_TOP_LOW = 5'h10;
  localparam logic [4:0] OFS_TOP_MID = 5'h14;
  localparam logic [4:0] OFS_TOP_UP  = 5'h18;
  localparam logic [4:0] OFS_CFG   = 5'h1C;
  localparam int BIT_FULL  = 7;
  localparam int BIT_UNF   = 6;
  localparam logic CFG_RESET = 1'b1;
  // Core operation codes.
  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_STEP   = 4'h1,
    OP_JUMP   = 4'h2,
    OP_CALL   = 4'h3,
    OP_RET    = 4'h4,
    OP_INT_HI = 4'h5,
    OP_INT_LO = 4'h6,
    OP_PUSH   = 4'h7,
    OP_POP    = 4'h8
  } pcrs_op_t;
endpackage

// ### pcrs_seq_model.sv
// Core sequencer model: presents one operation at a time and serves fetches.
// Assumes the bench never overlaps an operation with a bus access.
`timescale 1ns/100ps
module pcrs_seq_model
  import pcrs_pkg::*;
(
  // Clock and counter.
  input  wire logic            core_clk_i,
  input  wire logic [PC_W-1:0] pc_i,
  // Operation and memory word.
  output logic      [3:0]      op_o = OP_NONE,
  output logic      [PC_W-1:0] target_o = '0,
  output logic      [15:0]     fetch_data_o
);
  // The memory word differs at every even address below 20000h.
  assign fetch_data_o = pc_i[16:1] ^ 16'hA5A5;
  // One operation stands for one cycle; stack accesses never see an interrupt.
  task automatic issue(input logic [3:0] op, input logic [PC_W-1:0] tgt);
    @(posedge core_clk_i);
    op_o     <= op;
    target_o <= tgt;
    @(posedge core_clk_i);
    op_o     <= OP_NONE;
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the program counter and return stack block.
// Assumes the sequencer model drives operations and the bench drives Wishbone.
`timescale 1ns/100ps
module tb_top import pcrs_pkg::*;;
  logic            core_clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic            cyc_i = 1'b0;
  logic            we_i = 1'b0;
  logic [4:0]      adr_i = 5'h00;
  logic [7:0]      dat_b = 8'h00;
  logic [3:0]      op_i;
  logic [PC_W-1:0] target_i, pc_o, tv;
  logic [15:0]     fetch_data_i, fetch_word_o;
  logic [31:0]     dat_o;
  logic            ack_o, stack_reset_o;
  logic [7:0]      exp_q[$];
  integer          seed = 32'h11D0F4CB;
  int              n_errors = 0, n_tests = 0, cyc_n = 0;
  always #10 core_clk_i = ~core_clk_i;
  pcrs_core pcrs_core_inst (.core_clk_i, .rst_n_i, .por_n_i(rst_n_i), .op_i, .target_i,
    .pc_o, .stack_reset_o, .fetch_data_i, .fetch_word_o, .cyc_i, .stb_i(cyc_i), .we_i,
    .adr_i, .sel_i(4'h1), .dat_i({24'h0, dat_b}), .dat_o, .ack_o);
  pcrs_seq_model pcrs_seq_model_inst (.core_clk_i, .pc_i(pc_o), .op_o(op_i),
    .target_o(target_i), .fetch_data_o(fetch_data_i));
  // Counts mismatches and comparisons.
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("mismatch at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic summarize;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Classic single Wishbone cycle held until ack is sampled.
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    {cyc_i, we_i, adr_i, dat_b} <= {1'b1, w, a, d};
    @(posedge core_clk_i);
    while (ack_o !== 1'b1) @(posedge core_clk_i);
    cyc_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic chk_pc(input logic [PC_W-1:0] e);
    @(negedge core_clk_i);
    cmp({11'h0, e}, {11'h0, pc_o});
  endtask
  // Read answers are matched to the oldest note; a hang ends the run.
  always @(posedge core_clk_i)
  begin
    cyc_n++;
    if (ack_o === 1'b1 && we_i === 1'b0)
      cmp({24'h0, exp_q.pop_front()}, dat_o);
    if (cyc_n == 3000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    chk_pc(RESET_VEC);
    rd(OFS_STK, 8'h00);
    bus(1'b1, OFS_CFG, 8'h00);
    pcrs_seq_model_inst.issue(OP_STEP, 21'h0);
    chk_pc(PC_STEP);
    tv = 21'($random(seed));
    pcrs_seq_model_inst.issue(OP_JUMP, tv | 21'h1);
    chk_pc({tv[20:1], 1'b0});
    tv = 21'($random(seed));
    bus(1'b1, OFS_LATH, tv[15:8]);
    bus(1'b1, OFS_LATU, {3'h0, tv[20:16]});
    bus(1'b1, OFS_CNT_LOW, tv[7:0]);
    chk_pc({tv[20:1], 1'b0});
    pcrs_seq_model_inst.issue(OP_JUMP, 21'h12344);
    rd(OFS_CNT_LOW, 8'h44);
    rd(OFS_LATH, 8'h23);
    rd(OFS_LATU, 8'h01);
    pcrs_seq_model_inst.issue(OP_INT_HI, 21'h0);
    chk_pc(VEC_HIGH);
    rd(OFS_STK, 8'h01);
    bus(1'b1, OFS_TOP_LOW, 8'h56);
    bus(1'b1, OFS_TOP_MID, 8'h34);
    bus(1'b1, OFS_TOP_UP, 8'h02);
    pcrs_seq_model_inst.issue(OP_RET, 21'h0);
    chk_pc(21'h023456);
    rd(OFS_STK, 8'h00);
    pcrs_seq_model_inst.issue(OP_RET, 21'h0);
    chk_pc(RESET_VEC);
    rd(OFS_STK, 8'h40);
    pcrs_seq_model_inst.issue(OP_PUSH, 21'h0);
    rd(OFS_STK, 8'h41);
    pcrs_seq_model_inst.issue(OP_JUMP, 21'h0ABC0);
    pcrs_seq_model_inst.issue(OP_POP, 21'h0);
    chk_pc(21'h00ABC0);
    bus(1'b1, OFS_STK, 8'h00);
    rd(OFS_STK, 8'h00);
    pcrs_seq_model_inst.issue(OP_INT_LO, 21'h0);
    chk_pc(VEC_LOW);
    for (int i = 0; i < 30; i++) pcrs_seq_model_inst.issue(OP_CALL, 21'h100);
    rd(OFS_STK, 8'h9F);
    pcrs_seq_model_inst.issue(OP_CALL, 21'h100);
    rd(OFS_STK, 8'h9F);
    rd(5'h01, 8'h00);
    bus(1'b1, OFS_STK, 8'h00);
    bus(1'b1, OFS_CFG, 8'h01);
    pcrs_seq_model_inst.issue(OP_RET, 21'h0);
    @(negedge core_clk_i);
    tv[0] = stack_reset_o;
    @(negedge core_clk_i);
    cmp(32'h1, {31'h0, tv[0] | stack_reset_o});
    rd(OFS_STK, 8'h40);
    summarize();
  end
endmodule
